// file: logic/rim_meas_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rim_meas_if;
    logic meas_stb;
    logic meas_timeout;
    logic [31:0] meas_cycles;

    modport src (output meas_stb, output meas_timeout, output meas_cycles);
    modport dst (input meas_stb, input meas_timeout, input meas_cycles);
endinterface
`default_nettype wire

// file: logic/rim_period_meter.sv
`timescale 1ns/10ps
`default_nettype none
module rim_period_meter (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Monitored reference pin
    input wire logic reference_input_b,
    // Period measurements
    rim_meas_if.src meas
);

    logic sync1_reg, sync2_reg, sync3_reg, seen_edge_reg;
    logic [rim_pkg::CNT_W-1:0] cnt_reg;
    logic rise;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= reference_input_b;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~sync3_reg;

    // ----------------------------------------------------------------
    // Edge to edge counter
    // ----------------------------------------------------------------
    // A dead reference saturates the counter and reports one timeout,
    // so loss of clock is seen as a fault without a separate watchdog.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
            seen_edge_reg <= 1'b0;
            meas.meas_stb <= 1'b0;
            meas.meas_timeout <= 1'b0;
            meas.meas_cycles <= '0;
        end else begin
            meas.meas_stb <= 1'b0;
            meas.meas_timeout <= 1'b0;
            if (rise) begin
                cnt_reg <= '0;
                seen_edge_reg <= 1'b1;
                meas.meas_stb <= seen_edge_reg;
                meas.meas_cycles <= cnt_reg + 32'h1;
            end else if (cnt_reg != '1) begin
                cnt_reg <= cnt_reg + 32'h1;
                if (cnt_reg == ('1 - 32'h1)) begin
                    meas.meas_stb <= 1'b1;
                    meas.meas_timeout <= 1'b1;
                    meas.meas_cycles <= '1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: logic/rim_pkg.sv
package rim_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [13:0] IDX_PERIOD_0 = 14'h0444;
    localparam logic [13:0] IDX_PERIOD_TOP = 14'h044b;
    localparam logic [13:0] IDX_LIMIT_LOW = 14'h044c;
    localparam logic [13:0] IDX_LIMIT_MID = 14'h044d;
    localparam logic [13:0] IDX_LIMIT_HIGH = 14'h044e;
    localparam logic [13:0] IDX_HYSTERESIS = 14'h044f;
    localparam logic [13:0] IDX_VTIME_LOW = 14'h0450;
    localparam logic [13:0] IDX_VTIME_MID = 14'h0451;
    localparam logic [13:0] IDX_VTIME_HIGH = 14'h0452;
    localparam logic [13:0] IDX_JITTER_LOW = 14'h0453;
    localparam logic [13:0] IDX_JITTER_HIGH = 14'h0454;
    localparam logic [13:0] IDX_EVENT_STATUS = 14'h0458;
    localparam logic [13:0] IDX_EVENT_MASK = 14'h0459;
    localparam logic [13:0] IDX_LIVE_STATE = 14'h045a;

    // ----------------------------------------------------------------
    // Configuration byte array: entry 0 is the period low byte
    // ----------------------------------------------------------------
    localparam int CFG_ENTRIES = 17;
    localparam logic [135:0] CFG_RST = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h03, 8'h01, 8'h86, 8'ha0,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [135:0] CFG_MASK = {
        8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'hff,
        8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    // ----------------------------------------------------------------
    // Event status bits
    // ----------------------------------------------------------------
    localparam int EV_FAULT = 0;
    localparam int EV_VALID = 1;
    localparam int EV_JITTER = 2;
    localparam int EV_BITS = 3;

    // ----------------------------------------------------------------
    // Hysteresis codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HYS_NONE = 3'h0,
        HYS_3P125 = 3'h1,
        HYS_6P25 = 3'h2,
        HYS_12P5 = 3'h3,
        HYS_25 = 3'h4,
        HYS_50 = 3'h5,
        HYS_75 = 3'h6
    } rim_hys_t;

    // ----------------------------------------------------------------
    // Timing and scaling
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [35:0] CLK_PERIOD_AS = 36'd10000000000;
    localparam logic [29:0] PPB_SCALE = 30'd1000000000;
    localparam int CNT_W = 32;
    localparam int JIT_SHIFT = 4;

endpackage

// file: logic/rim_top.sv
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Hold 60-bit expected period in attoseconds
// - Fault when frequency error exceeds offset limit
// - 24-bit ppb offset limit, reset 0x0186a0
// - Programmable hysteresis on fault decision
// - Hysteresis code selects fraction, reset 3
// - Valid only after continuous in-tolerance duration
// - 20-bit millisecond validation time, reset ten
// - Excess jitter when rms exceeds threshold
// - 16-bit ns jitter threshold, zero disables
module rim_top #(
    parameter int MS_CYCLES = rim_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Monitored reference
    input wire logic reference_input_b,
    // Monitor status
    output logic ref_fault,
    output logic ref_valid,
    output logic jitter_excess,
    output logic irq
);

    // ----------------------------------------------------------------
    // Configuration storage
    // ----------------------------------------------------------------
    logic [7:0] cfg_reg [rim_pkg::CFG_ENTRIES];
    logic [13:0] idx;
    logic [13:0] cfg_off;
    logic in_cfg, addr_ok, wr_en;

    assign idx = paddr[15:2];
    assign cfg_off = idx - rim_pkg::IDX_PERIOD_0;
    assign in_cfg = (idx >= rim_pkg::IDX_PERIOD_0) && (idx <= rim_pkg::IDX_JITTER_HIGH);
    assign addr_ok = (paddr[1:0] == 2'h0) && (in_cfg || idx == rim_pkg::IDX_EVENT_STATUS
        || idx == rim_pkg::IDX_EVENT_MASK || idx == rim_pkg::IDX_LIVE_STATE);
    assign wr_en = psel && penable && pready && pwrite && addr_ok;

    // Reserved bits never store, so they read back as zero
    for (genvar i = 0; i < rim_pkg::CFG_ENTRIES; i++) begin : g_cfg
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                cfg_reg[i] <= rim_pkg::CFG_RST[i*8 +: 8];
            end else if (wr_en && in_cfg && cfg_off == 14'(i)) begin
                cfg_reg[i] <= pwdata[7:0] & rim_pkg::CFG_MASK[i*8 +: 8];
            end
        end
    end

    logic [59:0] expected_period;
    logic [23:0] offset_limit;
    logic [2:0] fault_hysteresis;
    logic [19:0] valid_time;
    logic [15:0] jitter_threshold;

    assign expected_period = {cfg_reg[7][3:0], cfg_reg[6], cfg_reg[5], cfg_reg[4],
        cfg_reg[3], cfg_reg[2], cfg_reg[1], cfg_reg[0]};
    assign offset_limit = {cfg_reg[10], cfg_reg[9], cfg_reg[8]};
    assign fault_hysteresis = cfg_reg[11][2:0];
    assign valid_time = {cfg_reg[14][3:0], cfg_reg[13], cfg_reg[12]};
    assign jitter_threshold = {cfg_reg[16], cfg_reg[15]};

    // ----------------------------------------------------------------
    // Period measurement
    // ----------------------------------------------------------------
    rim_meas_if meas_bus ();

    rim_period_meter u_meter (
        .mclk(mclk),
        .rstn(rstn),
        .reference_input_b(reference_input_b),
        .meas(meas_bus.src)
    );

    // ----------------------------------------------------------------
    // Frequency error against the offset limit
    // ----------------------------------------------------------------
    // Compared as |T - expected_period| * 1e9 against limit * expected_period, so no divider
    // is needed; the cost is a few wide multipliers.
    logic [67:0] meas_as, diff_as;
    logic [97:0] err_x, set_x, clr_x;
    logic [23:0] hys_amt, clr_limit;

    assign meas_as = 68'(meas_bus.meas_cycles) * 68'(rim_pkg::CLK_PERIOD_AS);
    assign diff_as = (meas_as > 68'(expected_period)) ? meas_as - 68'(expected_period)
        : 68'(expected_period) - meas_as;
    assign err_x = 98'(diff_as) * 98'(rim_pkg::PPB_SCALE);
    assign set_x = 98'(offset_limit) * 98'(expected_period);
    assign clr_x = 98'(clr_limit) * 98'(expected_period);

    always_comb begin
        case (rim_pkg::rim_hys_t'(fault_hysteresis))
            rim_pkg::HYS_NONE: hys_amt = 24'h0;
            rim_pkg::HYS_3P125: hys_amt = offset_limit >> 5;
            rim_pkg::HYS_6P25: hys_amt = offset_limit >> 4;
            rim_pkg::HYS_12P5: hys_amt = offset_limit >> 3;
            rim_pkg::HYS_25: hys_amt = offset_limit >> 2;
            rim_pkg::HYS_50: hys_amt = offset_limit >> 1;
            rim_pkg::HYS_75: hys_amt = (offset_limit >> 1) + (offset_limit >> 2);
            default: hys_amt = 24'h0;
        endcase
    end

    assign clr_limit = offset_limit - hys_amt;

    logic fault_reg;

    // Fault sets above the limit and clears only at or below limit minus band
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fault_reg <= 1'b1;
        end else if (meas_bus.meas_stb) begin
            if (meas_bus.meas_timeout) begin
                fault_reg <= 1'b1;
            end else if (!fault_reg && err_x > set_x) begin
                fault_reg <= 1'b1;
            end else if (fault_reg && err_x <= clr_x) begin
                fault_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Validation timer
    // ----------------------------------------------------------------
    logic [31:0] ms_div_reg;
    logic ms_tick_reg;
    logic [19:0] vtimer_reg;
    logic valid_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ms_div_reg <= '0;
            ms_tick_reg <= 1'b0;
        end else if (fault_reg) begin
            // Restart while faulted, so a part millisecond never counts
            ms_div_reg <= '0;
            ms_tick_reg <= 1'b0;
        end else if (ms_div_reg == 32'(MS_CYCLES - 1)) begin
            ms_div_reg <= '0;
            ms_tick_reg <= 1'b1;
        end else begin
            ms_div_reg <= ms_div_reg + 32'h1;
            ms_tick_reg <= 1'b0;
        end
    end

    // Any fault wipes the elapsed time, so validity needs a whole interval
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            vtimer_reg <= '0;
        end else if (fault_reg) begin
            vtimer_reg <= '0;
        end else if (ms_tick_reg && vtimer_reg != '1) begin
            vtimer_reg <= vtimer_reg + 20'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= !fault_reg && (vtimer_reg >= valid_time);
        end
    end

    // ----------------------------------------------------------------
    // Jitter estimate
    // ----------------------------------------------------------------
    // Period to period deviation squared, averaged by a 1/16 leaky
    // integrator; the accumulator settles at 16 times the mean square.
    logic [31:0] prev_cycles_reg;
    logic prev_ok_reg;
    logic [31:0] dev_cyc;
    logic [19:0] dev_ns;
    logic [43:0] acc_reg;
    logic [43:0] thr_sq;
    logic jitter_reg;

    assign dev_cyc = (meas_bus.meas_cycles > prev_cycles_reg)
        ? meas_bus.meas_cycles - prev_cycles_reg : prev_cycles_reg - meas_bus.meas_cycles;
    assign dev_ns = (dev_cyc > 32'h0001_869f) ? 20'hf_ffff
        : 20'(dev_cyc * 32'(rim_pkg::CLK_PERIOD_NS));
    assign thr_sq = {4'h0, 32'(jitter_threshold) * 32'(jitter_threshold), 8'h00}
        >> (8 - rim_pkg::JIT_SHIFT);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prev_cycles_reg <= '0;
            prev_ok_reg <= 1'b0;
            acc_reg <= '0;
        end else if (meas_bus.meas_stb) begin
            prev_cycles_reg <= meas_bus.meas_cycles;
            prev_ok_reg <= !meas_bus.meas_timeout;
            if (prev_ok_reg && !meas_bus.meas_timeout) begin
                acc_reg <= acc_reg - (acc_reg >> rim_pkg::JIT_SHIFT)
                    + 44'(40'(dev_ns) * 40'(dev_ns));
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            jitter_reg <= 1'b0;
        end else begin
            jitter_reg <= (jitter_threshold != 16'h0) && (acc_reg > thr_sq);
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    logic fault_d_reg, valid_d_reg, jitter_d_reg;
    logic [rim_pkg::EV_BITS-1:0] ev_status_reg, ev_mask_reg, ev_set, ev_clr;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fault_d_reg <= 1'b1;
            valid_d_reg <= 1'b0;
            jitter_d_reg <= 1'b0;
        end else begin
            fault_d_reg <= fault_reg;
            valid_d_reg <= valid_reg;
            jitter_d_reg <= jitter_reg;
        end
    end

    always_comb begin
        ev_set = '0;
        ev_set[rim_pkg::EV_FAULT] = fault_reg && !fault_d_reg;
        ev_set[rim_pkg::EV_VALID] = valid_reg && !valid_d_reg;
        ev_set[rim_pkg::EV_JITTER] = jitter_reg && !jitter_d_reg;
    end

    assign ev_clr = (wr_en && idx == rim_pkg::IDX_EVENT_STATUS)
        ? pwdata[rim_pkg::EV_BITS-1:0] : '0;

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ev_status_reg <= '0;
        end else begin
            ev_status_reg <= (ev_status_reg & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ev_mask_reg <= '0;
        end else if (wr_en && idx == rim_pkg::IDX_EVENT_MASK) begin
            ev_mask_reg <= pwdata[rim_pkg::EV_BITS-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
            ref_fault <= 1'b1;
            ref_valid <= 1'b0;
            jitter_excess <= 1'b0;
        end else begin
            irq <= |(ev_status_reg & ev_mask_reg);
            ref_fault <= fault_reg;
            ref_valid <= valid_reg;
            jitter_excess <= jitter_reg;
        end
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    // One wait state: pready rises in the second access cycle so that
    // read data and error come straight from flip-flops.
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        if (in_cfg) begin
            rd_mux = {24'h0, cfg_reg[cfg_off[4:0]]};
        end else if (idx == rim_pkg::IDX_EVENT_STATUS) begin
            rd_mux = 32'(ev_status_reg);
        end else if (idx == rim_pkg::IDX_EVENT_MASK) begin
            rd_mux = 32'(ev_mask_reg);
        end else if (idx == rim_pkg::IDX_LIVE_STATE) begin
            rd_mux = {29'h0, jitter_reg, valid_reg, fault_reg};
        end
        if (!addr_ok) begin
            rd_mux = 32'h0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= pwrite ? 32'h0 : rd_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: sim/rim_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rim_properties #(
    parameter int MS_CYCLES = rim_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Reference and status
    input wire logic reference_input_b,
    input wire logic ref_fault,
    input wire logic ref_valid,
    input wire logic jitter_excess,
    input wire logic irq
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    sequence s_first_access;
        psel && penable && !pready;
    endsequence
    sequence s_one_answer;
        pready ##1 !pready;
    endsequence

    chk_apb_answer: assert property (s_first_access |=> s_one_answer)
        else $error("pready is not one pulse one cycle after the access phase");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    chk_idle_no_ready: assert property (!psel |=> !pready)
        else $error("pready after an idle cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned nonzero data");
    chk_rdata_held: assert property (!pready |-> $stable(prdata))
        else $error("prdata changed outside an answer");

    // ----------------------------------------------------------------
    // Qualification
    // ----------------------------------------------------------------
    // Valid must not outlive a fault, so validation restarts from zero
    sequence s_faulted;
        ref_fault [*3];
    endsequence

    chk_fault_kills_valid: assert property (s_faulted |-> !ref_valid)
        else $error("valid held while faulted");
    chk_valid_after_good: assert property ($rose(ref_valid) |-> !ref_fault && !$past(ref_fault))
        else $error("valid rose without an in-tolerance reference");
endmodule

bind rim_top rim_properties #(.MS_CYCLES(MS_CYCLES)) u_props (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_input_b(reference_input_b), .ref_fault(ref_fault), .ref_valid(ref_valid),
    .jitter_excess(jitter_excess), .irq(irq)
);
`default_nettype wire

// file: sim/rim_ref_source.sv
`timescale 1ns/10ps
`default_nettype none
module rim_ref_source (
    // Control from the bench
    input wire logic run,
    input wire logic [31:0] period_ns,
    input wire logic [31:0] wobble_ns,
    // Reference pin
    output logic ref_clk
);
    // ----------------------------------------------------------------
    // Free-running reference, every other period stretched by wobble
    // ----------------------------------------------------------------
    logic odd;

    // The 2.5 ns offset keeps rising edges off the system clock edge,
    // so the measured period never jitters by a cycle
    initial begin
        ref_clk = 1'b0;
        odd = 1'b0;
        wait (run);
        #2.5;
        forever begin
            #(period_ns / 2) ref_clk = 1'b1;
            #(period_ns - period_ns / 2 + (odd ? wobble_ns : 32'h0)) ref_clk = 1'b0;
            odd = !odd;
        end
    end
endmodule
`default_nettype wire

// file: sim/rim_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rim_top_tb;
    localparam int MSC = 10;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ref_b, ref_fault, ref_valid, jitter_excess, irq;
    logic run = 1'b0;
    logic [31:0] per_ns = 32'd5000;
    logic [31:0] wob_ns = 32'd0;
    int errors = 0;
    int n_checks = 0;

    always #5 mclk = ~mclk;

    rim_top #(.MS_CYCLES(MSC)) dut (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_input_b(ref_b), .ref_fault(ref_fault), .ref_valid(ref_valid),
        .jitter_excess(jitter_excess), .irq(irq)
    );
    rim_ref_source src (.run(run), .period_ns(per_ns), .wobble_ns(wob_ns), .ref_clk(ref_b));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check(32'h0, 32'h1);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic e;
        apb(1'b1, idx, wd, rd, e);
    endtask

    task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, idx, 32'h0, rd, e);
        check(rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Watched status output: 0 fault, 1 valid, 2 jitter
    function automatic logic status_bit(input int sel);
        return (sel == 0) ? ref_fault : (sel == 1) ? ref_valid : jitter_excess;
    endfunction

    task automatic wait_for(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (status_bit(sel) !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (n >= lim) begin
            check(32'h0, 32'h1);
            print_verdict();
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] rv [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'ha0, 8'h86, 8'h01, 8'h03, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [31:0] rd;
        logic e;
        for (int i = 0; i < 17; i++) begin
            rd_chk(rim_pkg::IDX_PERIOD_0 + 14'(i), {24'h0, rv[i]});
        end
        wr(rim_pkg::IDX_PERIOD_TOP, 32'hff);
        rd_chk(rim_pkg::IDX_PERIOD_TOP, 32'h0f);
        wr(rim_pkg::IDX_HYSTERESIS, 32'hff);
        rd_chk(rim_pkg::IDX_HYSTERESIS, 32'h07);
        wr(rim_pkg::IDX_VTIME_HIGH, 32'hff);
        rd_chk(rim_pkg::IDX_VTIME_HIGH, 32'h0f);
        wr(rim_pkg::IDX_JITTER_HIGH, 32'h1a5);
        rd_chk(rim_pkg::IDX_JITTER_HIGH, 32'ha5);
        // Unmapped index just past the jitter threshold
        apb(1'b1, 14'h0455, 32'hff, rd, e);
        check(e, 1'b1);
        apb(1'b0, 14'h0455, 32'h0, rd, e);
        check(32'(e), 32'h1);
        check(rd, 32'h0);
        wr(rim_pkg::IDX_PERIOD_TOP, 32'h0);
        wr(rim_pkg::IDX_VTIME_HIGH, 32'h0);
        wr(rim_pkg::IDX_JITTER_HIGH, 32'h0);
    endtask

    task automatic t_hyst;
        // 5 us nominal period in attoseconds, low byte first
        logic [7:0] pb [6] = '{8'h00, 8'h50, 8'h39, 8'h27, 8'h8c, 8'h04};
        // Largest error, in cycles of 2e6 ppb, that clears a 16e6 ppb limit per code
        int dt [8] = '{8, 7, 7, 7, 6, 4, 2, 8};
        int n;
        for (int i = 0; i < 6; i++) wr(rim_pkg::IDX_PERIOD_0 + 14'(i), {24'h0, pb[i]});
        wr(rim_pkg::IDX_LIMIT_LOW, 32'h00);
        wr(rim_pkg::IDX_LIMIT_MID, 32'h24);
        wr(rim_pkg::IDX_LIMIT_HIGH, 32'hf4);
        wr(rim_pkg::IDX_VTIME_LOW, 32'h03);
        run <= 1'b1;
        wait_for(0, 1'b0, 20000, n);
        check(ref_fault, 1'b0);
        for (int c = 0; c < 8; c++) begin
            wr(rim_pkg::IDX_HYSTERESIS, 32'(c));
            per_ns <= 32'd5090;
            cyc(1600);
            check(ref_fault, 1'b1);
            per_ns <= 32'((501 + dt[c]) * 10);
            cyc(1600);
            check(ref_fault, 1'b1);
            per_ns <= 32'((500 + dt[c]) * 10);
            cyc(1600);
            check(ref_fault, 1'b0);
        end
    endtask

    task automatic t_valid;
        int n;
        wr(rim_pkg::IDX_EVENT_STATUS, 32'h7);
        wr(rim_pkg::IDX_EVENT_MASK, 32'h2);
        per_ns <= 32'd5090;
        wait_for(0, 1'b1, 3000, n);
        cyc(3);
        check(ref_valid, 1'b0);
        check(irq, 1'b0);
        per_ns <= 32'd5000;
        wait_for(0, 1'b0, 3000, n);
        wait_for(1, 1'b1, 100, n);
        // Validation time is 3 ms; the count starts two cycles after the fault cleared
        check(n >= 3 * MSC - 2 && n <= 3 * MSC + 3, 1'b1);
        rd_chk(rim_pkg::IDX_LIVE_STATE, 32'h2);
        rd_chk(rim_pkg::IDX_EVENT_MASK, 32'h2);
        cyc(3);
        check(irq, 1'b1);
        rd_chk(rim_pkg::IDX_EVENT_STATUS, 32'h3);
        wr(rim_pkg::IDX_EVENT_STATUS, 32'h3);
        cyc(3);
        check(irq, 1'b0);
        rd_chk(rim_pkg::IDX_EVENT_STATUS, 32'h0);
    endtask

    task automatic t_jitter;
        int n;
        wob_ns <= 32'd100;
        cyc(6000);
        check(jitter_excess, 1'b0);
        wr(rim_pkg::IDX_JITTER_LOW, 32'd50);
        wait_for(2, 1'b1, 20000, n);
        check(jitter_excess, 1'b1);
        wr(rim_pkg::IDX_JITTER_LOW, 32'd0);
        cyc(5);
        check(jitter_excess, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_hyst();
        t_valid();
        t_jitter();
        print_verdict();
    end
endmodule
`default_nettype wire
